// File: ssc_params.svh
`ifndef SSC_PARAMS_SVH
`define SSC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register placement
// ----------------------------------------------------------------------
`define SSC_CFG_OFFSET 8'h80
`define SSC_AW 8
`define SSC_DW 32

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SSC_B_PIN_DRIVE 22
`define SSC_B_PROT_DIS 21
`define SSC_B_RSV_HI 20
`define SSC_B_RSV_LO 16
`define SSC_B_BURST_DN 15
`define SSC_B_BURST_UP 14
`define SSC_B_ACTIVITY 13
`define SSC_B_ONE 12
`define SSC_B_STREAM 11
`define SSC_B_UP_WAIT 10
`define SSC_B_DN_WAIT 9
`define SSC_B_PROBE 8
`define SSC_B_ZERO 7
`define SSC_B_LOW_PWR 6
`define SSC_B_ID_LOCK 5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SSC_RST_PIN_DRIVE 1'b1
`define SSC_RST_PROT_DIS 1'b0
`define SSC_RST_RSV 5'h00
`define SSC_RST_BURST_DN 1'b1
`define SSC_RST_BURST_UP 1'b0
`define SSC_RST_LOW_PWR 1'b1
`define SSC_RST_ID_LOCK 1'b1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SSC_CLK_NS 4
`define SSC_STREAM_NS 1000
`define SSC_UP_DLY_NS 10000
`define SSC_DN_DLY_NS 4000
`define SSC_STREAM_CYC ((`SSC_STREAM_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS)
`define SSC_UP_DLY_CYC ((`SSC_UP_DLY_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS)
`define SSC_DN_DLY_CYC ((`SSC_DN_DLY_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS)
`define SSC_CNT_W 12

`endif

// File: ssc_pkg.sv
package ssc_pkg;

  // ----------------------------------------------------------------------
  // Power sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SSC_PS_IDLE = 2'h0,
    SSC_PS_STREAM = 2'h1,
    SSC_PS_DELAY = 2'h3
  } ssc_pwr_state_t;

endpackage : ssc_pkg

// File: ssc_pwr_seq.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssc_params.svh"

module ssc_pwr_seq (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic pme_en,
  input wire logic req,
  input wire logic up,
  output logic busy,
  output logic up_wait,
  output logic down_wait
);

  ssc_pkg::ssc_pwr_state_t state_r, state_nxt;
  logic [`SSC_CNT_W-1:0] cnt_r, cnt_nxt;
  logic dir_r, dir_nxt;
  logic busy_r, busy_nxt;
  logic upw_r, upw_nxt;
  logic dnw_r, dnw_nxt;

  // ----------------------------------------------------------------------
  // Stream and delay sequencing
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    dir_nxt = dir_r;
    upw_nxt = upw_r;
    dnw_nxt = dnw_r;
    case (state_r)
      ssc_pkg::SSC_PS_IDLE: begin
        if (req) begin
          state_nxt = ssc_pkg::SSC_PS_STREAM;
          cnt_nxt = `SSC_CNT_W'(`SSC_STREAM_CYC - 1);
          dir_nxt = up;
        end
      end
      ssc_pkg::SSC_PS_STREAM: begin
        if (cnt_r == '0) begin
          state_nxt = ssc_pkg::SSC_PS_DELAY;
          cnt_nxt = dir_r ? `SSC_CNT_W'(`SSC_UP_DLY_CYC - 1)
                          : `SSC_CNT_W'(`SSC_DN_DLY_CYC - 1);
          upw_nxt = dir_r; // [RQ10]
          dnw_nxt = ~dir_r; // [RQ11]
        end else begin
          cnt_nxt = cnt_r - `SSC_CNT_W'(1);
        end
      end
      ssc_pkg::SSC_PS_DELAY: begin
        if (cnt_r == '0) begin
          state_nxt = ssc_pkg::SSC_PS_IDLE;
          upw_nxt = 1'b0; // [RQ10]
          dnw_nxt = 1'b0; // [RQ11]
        end else begin
          cnt_nxt = cnt_r - `SSC_CNT_W'(1);
        end
      end
      default: begin
        state_nxt = ssc_pkg::SSC_PS_IDLE;
      end
    endcase
    busy_nxt = (state_nxt != ssc_pkg::SSC_PS_IDLE); // [RQ9]
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= ssc_pkg::SSC_PS_IDLE;
      cnt_r <= '0;
      dir_r <= 1'b0;
      busy_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      dir_r <= dir_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Wait flags carry context: the reset clears them only with events off.
  always_ff @(posedge core_clk) begin
    if (rst && !pme_en) begin // [RQ16]
      upw_r <= 1'b0;
      dnw_r <= 1'b0;
    end else if (!rst && ce) begin
      upw_r <= upw_nxt;
      dnw_r <= dnw_nxt;
    end
  end

  assign busy = busy_r;
  assign up_wait = upw_r;
  assign down_wait = dnw_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_req_busy;
    @(posedge core_clk) disable iff (rst)
    (ce && req && state_r == ssc_pkg::SSC_PS_IDLE) |=> busy_r;
  endproperty
  a_req_busy: assert property (p_req_busy) else $error("busy not raised"); // [RQ9]

  property p_up_set;
    @(posedge core_clk) disable iff (rst)
    (ce && state_r == ssc_pkg::SSC_PS_STREAM && cnt_r == '0 && dir_r)
      |=> (upw_r && !dnw_r && busy_r);
  endproperty
  a_up_set: assert property (p_up_set) else $error("up wait not set"); // [RQ10]

  property p_dn_set;
    @(posedge core_clk) disable iff (rst)
    (ce && state_r == ssc_pkg::SSC_PS_STREAM && cnt_r == '0 && !dir_r)
      |=> (dnw_r && !upw_r);
  endproperty
  a_dn_set: assert property (p_dn_set) else $error("down wait not set"); // [RQ11]

  property p_end_clear;
    @(posedge core_clk) disable iff (rst)
    (ce && state_r == ssc_pkg::SSC_PS_DELAY && cnt_r == '0)
      |=> (!busy_r && !upw_r && !dnw_r);
  endproperty
  a_end_clear: assert property (p_end_clear) else $error("flags stuck"); // [RQ9]

  c_up_seq: cover property (@(posedge core_clk) disable iff (rst)
    $fell(upw_r));

endmodule : ssc_pwr_seq

`default_nettype wire

// File: ssc_config.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssc_params.svh"

// Overview of operation
// (RQ1) Drive reserved pins low when enabled and present.
// (RQ2) Bit 21 set disables 16-bit supply protection.
// (RQ3) Software keeps bits 20-16 unchanged on writes.
// (RQ4) Toward-card read bursts only while bit 15.
// (RQ5) Toward-host read bursts only while bit 14.
// (RQ6) Activity flag sets on access, clears on read.
// (RQ7) Bit 12 always reads one.
// (RQ8) Bit 7 always reads zero.
// (RQ9) Stream flag high until stream and delay done.
// (RQ10) Up-wait set after up stream, cleared on expiry.
// (RQ11) Down-wait set after down stream, cleared on expiry.
// (RQ12) Probe flag high while interrogation runs.
// (RQ13) Shared power-savings bit selects reduced-power mode.
// (RQ14) Lock bit makes identity registers read-only.
// (RQ15) Writable fields reset only by global reset.
// (RQ16) Context flags survive reset while events enabled.
// (RQ17) Global fields written only through function zero.
module ssc_config (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic cfg_rd,
  input wire logic cfg_wr,
  input wire logic cfg_func,
  input wire logic [`SSC_AW-1:0] cfg_addr,
  input wire logic [`SSC_DW-1:0] cfg_wdata,
  input wire logic [3:0] cfg_be,
  output logic [`SSC_DW-1:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire logic pme_en,
  input wire logic [1:0] card_access,
  input wire logic [1:0] probe_start,
  input wire logic [1:0] probe_done,
  input wire logic [1:0] pwr_req,
  input wire logic [1:0] pwr_up,
  input wire logic [1:0] cb_present_pin,
  output logic [1:0] rsvd_pin_o,
  output logic [1:0] rsvd_pin_oe,
  output logic [1:0] supply_protect_disable,
  output logic read_burst_toward_card,
  output logic read_burst_toward_host,
  output logic low_power_enable,
  output logic identity_write_lock
);

  logic hit;
  logic [1:0] drv_r, drv_nxt, prot_r, prot_nxt;
  logic [4:0] rsv_r [2];
  logic [4:0] rsv_nxt [2];
  logic [1:0] act_r, act_nxt, probe_r, probe_nxt;
  logic bdn_r, bdn_nxt, bup_r, bup_nxt, lps_r, lps_nxt, lock_r, lock_nxt;
  logic [1:0] sy1_r, sy2_r, oe_r, oe_nxt, pin_r;
  logic [`SSC_DW-1:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] busy, upw, dnw;

  assign hit = (cfg_addr == `SSC_CFG_OFFSET);

  // ----------------------------------------------------------------------
  // Per-socket fields
  // ----------------------------------------------------------------------
  for (genvar s = 0; s < 2; s++) begin : g_sock
    logic wsel;
    assign wsel = ce && cfg_wr && hit && (cfg_func == s[0]);

    always_comb begin
      drv_nxt[s] = drv_r[s];
      prot_nxt[s] = prot_r[s];
      rsv_nxt[s] = rsv_r[s];
      if (wsel && cfg_be[2]) begin
        drv_nxt[s] = cfg_wdata[`SSC_B_PIN_DRIVE]; // [RQ1]
        prot_nxt[s] = cfg_wdata[`SSC_B_PROT_DIS]; // [RQ2]
        // Stored as written; software is trusted to write back. [RQ3]
        rsv_nxt[s] = cfg_wdata[`SSC_B_RSV_HI:`SSC_B_RSV_LO];
      end
      // A new access in the read cycle keeps the flag. [RQ6]
      act_nxt[s] = card_access[s] |
        (act_r[s] & ~(cfg_rd && hit && cfg_func == s[0]));
      probe_nxt[s] = probe_start[s] | (probe_r[s] & ~probe_done[s]); // [RQ12]
      oe_nxt[s] = drv_r[s] & sy2_r[s]; // [RQ1]
    end

    ssc_pwr_seq u_pwr (
      .core_clk(core_clk),
      .rst(rst),
      .ce(ce),
      .pme_en(pme_en),
      .req(pwr_req[s]),
      .up(pwr_up[s]),
      .busy(busy[s]),
      .up_wait(upw[s]),
      .down_wait(dnw[s])
    );
  end

  // ----------------------------------------------------------------------
  // Shared fields and read path
  // ----------------------------------------------------------------------
  always_comb begin
    bdn_nxt = bdn_r;
    bup_nxt = bup_r;
    lps_nxt = lps_r;
    lock_nxt = lock_r;
    // Function one cannot touch the shared fields. [RQ17]
    if (ce && cfg_wr && hit && !cfg_func) begin
      if (cfg_be[1]) begin
        bdn_nxt = cfg_wdata[`SSC_B_BURST_DN]; // [RQ4]
        bup_nxt = cfg_wdata[`SSC_B_BURST_UP]; // [RQ5]
      end
      if (cfg_be[0]) begin
        lps_nxt = cfg_wdata[`SSC_B_LOW_PWR]; // [RQ13]
        lock_nxt = cfg_wdata[`SSC_B_ID_LOCK]; // [RQ14]
      end
    end
    rvalid_nxt = cfg_rd;
    rdata_nxt = '0;
    if (cfg_rd && hit) begin
      rdata_nxt[`SSC_B_PIN_DRIVE] = drv_r[cfg_func];
      rdata_nxt[`SSC_B_PROT_DIS] = prot_r[cfg_func];
      rdata_nxt[`SSC_B_RSV_HI:`SSC_B_RSV_LO] = rsv_r[cfg_func];
      rdata_nxt[`SSC_B_BURST_DN] = bdn_r;
      rdata_nxt[`SSC_B_BURST_UP] = bup_r;
      rdata_nxt[`SSC_B_ACTIVITY] = act_r[cfg_func];
      rdata_nxt[`SSC_B_ONE] = 1'b1; // [RQ7]
      rdata_nxt[`SSC_B_STREAM] = busy[cfg_func]; // [RQ9]
      rdata_nxt[`SSC_B_UP_WAIT] = upw[cfg_func];
      rdata_nxt[`SSC_B_DN_WAIT] = dnw[cfg_func];
      rdata_nxt[`SSC_B_PROBE] = probe_r[cfg_func];
      rdata_nxt[`SSC_B_ZERO] = 1'b0; // [RQ8]
      rdata_nxt[`SSC_B_LOW_PWR] = lps_r;
      rdata_nxt[`SSC_B_ID_LOCK] = lock_r;
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Only the global reset pin reaches these; no bus reset exists here.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin // [RQ15]
      drv_r <= {2{`SSC_RST_PIN_DRIVE}};
      prot_r <= {2{`SSC_RST_PROT_DIS}};
      rsv_r[0] <= `SSC_RST_RSV;
      rsv_r[1] <= `SSC_RST_RSV;
      act_r <= 2'h0;
      bdn_r <= `SSC_RST_BURST_DN;
      bup_r <= `SSC_RST_BURST_UP;
      lps_r <= `SSC_RST_LOW_PWR;
      lock_r <= `SSC_RST_ID_LOCK;
      sy1_r <= 2'h0;
      sy2_r <= 2'h0;
      oe_r <= 2'h0;
      pin_r <= 2'h0;
      rdata_r <= '0;
      rvalid_r <= 1'b0;
    end else if (ce) begin
      drv_r <= drv_nxt;
      prot_r <= prot_nxt;
      rsv_r[0] <= rsv_nxt[0];
      rsv_r[1] <= rsv_nxt[1];
      act_r <= act_nxt;
      bdn_r <= bdn_nxt;
      bup_r <= bup_nxt;
      lps_r <= lps_nxt;
      lock_r <= lock_nxt;
      sy1_r <= cb_present_pin;
      sy2_r <= sy1_r;
      oe_r <= oe_nxt;
      pin_r <= 2'h0;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  // Probe flags are context: kept across reset while events are enabled.
  always_ff @(posedge core_clk) begin
    if (rst && !pme_en) begin // [RQ16]
      probe_r <= 2'h0;
    end else if (!rst && ce) begin
      probe_r <= probe_nxt;
    end
  end

  assign cfg_rdata = rdata_r;
  assign cfg_rvalid = rvalid_r;
  assign rsvd_pin_o = pin_r;
  assign rsvd_pin_oe = oe_r;
  assign supply_protect_disable = prot_r;
  assign read_burst_toward_card = bdn_r;
  assign read_burst_toward_host = bup_r;
  assign low_power_enable = lps_r;
  assign identity_write_lock = lock_r;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  property p_fixed_one;
    @(posedge core_clk) disable iff (rst)
    (ce && cfg_rd && hit) |=> cfg_rdata[`SSC_B_ONE];
  endproperty
  a_fixed_one: assert property (p_fixed_one) else $error("bit 12 not one"); // [RQ7]

  property p_fixed_zero;
    @(posedge core_clk) disable iff (rst)
    (ce && cfg_rd && hit) |=> !cfg_rdata[`SSC_B_ZERO] && cfg_rvalid;
  endproperty
  a_fixed_zero: assert property (p_fixed_zero) else $error("bit 7 not zero"); // [RQ8]

  property p_act_clear;
    @(posedge core_clk) disable iff (rst)
    (ce && cfg_rd && hit && !cfg_func && !card_access[0]) |=> !act_r[0];
  endproperty
  a_act_clear: assert property (p_act_clear) else $error("activity kept"); // [RQ6]

  property p_act_set;
    @(posedge core_clk) disable iff (rst)
    (ce && card_access[1]) |=> act_r[1];
  endproperty
  a_act_set: assert property (p_act_set) else $error("activity lost"); // [RQ6]

  property p_pin_drive;
    @(posedge core_clk) disable iff (rst)
    (ce && drv_r[0] && sy2_r[0]) |=> (rsvd_pin_oe[0] && !rsvd_pin_o[0]);
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not driven"); // [RQ1]

  property p_func1_wr;
    @(posedge core_clk) disable iff (rst)
    (ce && cfg_wr && cfg_func) |=> ($stable(bdn_r) && $stable(lock_r));
  endproperty
  a_func1_wr: assert property (p_func1_wr) else $error("global via fn1"); // [RQ17]

  property p_burst_wr;
    @(posedge core_clk) disable iff (rst)
    (ce && cfg_wr && hit && !cfg_func && cfg_be[1])
      |=> (read_burst_toward_host == $past(cfg_wdata[`SSC_B_BURST_UP]));
  endproperty
  a_burst_wr: assert property (p_burst_wr) else $error("burst bit wrong"); // [RQ5]

  c_read_hit: cover property (@(posedge core_clk) disable iff (rst)
    cfg_rvalid && cfg_rdata[`SSC_B_ACTIVITY]);
  c_probe: cover property (@(posedge core_clk) disable iff (rst)
    $fell(probe_r[0]));
  c_stream: cover property (@(posedge core_clk) disable iff (rst)
    $fell(busy[1]));

endmodule : ssc_config

`default_nettype wire

// File: tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssc_params.svh"

module tb_top;
  logic core_clk, rst, ce, cfg_rd, cfg_wr, cfg_func, pme_en, cfg_rvalid;
  logic [7:0] cfg_addr;
  logic [31:0] cfg_wdata, cfg_rdata, seed, d;
  logic [3:0] cfg_be;
  logic [1:0] card_access, probe_start, probe_done, pwr_req, pwr_up;
  logic [1:0] cb_present_pin, rsvd_pin_o, rsvd_pin_oe;
  logic [1:0] supply_protect_disable;
  logic read_burst_toward_card, read_burst_toward_host;
  logic low_power_enable, identity_write_lock;
  logic [31:0] exp_q[$];
  int error_cnt, n_checks;
  // ----------------------------------------------------------------------
  // Expected register contents
  // ----------------------------------------------------------------------
  logic [1:0] pd, pr, act, st, uw, dw, pb;
  logic [4:0] rsv [2];
  logic dn, up, lp, lk;

  ssc_config dut (.core_clk(core_clk), .rst(rst), .ce(ce),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_func(cfg_func),
    .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_be(cfg_be),
    .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .pme_en(pme_en),
    .card_access(card_access), .probe_start(probe_start),
    .probe_done(probe_done), .pwr_req(pwr_req), .pwr_up(pwr_up),
    .cb_present_pin(cb_present_pin), .rsvd_pin_o(rsvd_pin_o),
    .rsvd_pin_oe(rsvd_pin_oe),
    .supply_protect_disable(supply_protect_disable),
    .read_burst_toward_card(read_burst_toward_card),
    .read_burst_toward_host(read_burst_toward_host),
    .low_power_enable(low_power_enable),
    .identity_write_lock(identity_write_lock));

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
  endfunction : lfsr

  function automatic logic [31:0] img(input logic f);
    img = {9'h000, pd[f], pr[f], rsv[f], dn, up, act[f], 1'b1, st[f],
      uw[f], dw[f], pb[f], 1'b0, lp, lk, 5'h00};
  endfunction : img

  task automatic chk(input string nm, input logic [31:0] seen,
    input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  // ----------------------------------------------------------------------
  // Bus and pin drivers
  // ----------------------------------------------------------------------
  task automatic rd(input logic f, input logic [7:0] a);
    @(negedge core_clk);
    exp_q.push_back((a == `SSC_CFG_OFFSET) ? img(f) : 32'h00000000);
    if (a == `SSC_CFG_OFFSET)
      act[f] = 1'b0;
    cfg_func = f;
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge core_clk);
    cfg_rd = 1'b0;
  endtask : rd

  task automatic wr(input logic f, input logic [7:0] a,
    input logic [31:0] dat, input logic [3:0] be);
    @(negedge core_clk);
    cfg_func = f;
    cfg_addr = a;
    cfg_wdata = dat;
    cfg_be = be;
    cfg_wr = 1'b1;
    if (a == `SSC_CFG_OFFSET && be[2]) begin
      pd[f] = dat[22];
      pr[f] = dat[21];
      rsv[f] = dat[20:16];
    end
    // Function one may not touch the shared fields.
    if (a == `SSC_CFG_OFFSET && be[1] && !f) begin
      dn = dat[15];
      up = dat[14];
    end
    if (a == `SSC_CFG_OFFSET && be[0] && !f) begin
      lp = dat[6];
      lk = dat[5];
    end
    @(negedge core_clk);
    cfg_wr = 1'b0;
  endtask : wr

  task automatic pulse(input int k, input logic [1:0] m);
    @(negedge core_clk);
    case (k)
      0: card_access = m;
      1: probe_start = m;
      2: probe_done = m;
      default: pwr_req = m;
    endcase
    @(negedge core_clk);
    card_access = 2'b00;
    probe_start = 2'b00;
    probe_done = 2'b00;
    pwr_req = 2'b00;
  endtask : pulse

  task automatic outs();
    repeat (4) @(negedge core_clk);
    chk("burst_dn", read_burst_toward_card, dn);
    chk("burst_up", read_burst_toward_host, up);
    chk("low_pwr", low_power_enable, lp);
    chk("id_lock", identity_write_lock, lk);
    chk("prot_dis", supply_protect_disable, pr);
    chk("pin_oe", rsvd_pin_oe, pd & cb_present_pin);
    chk("pin_o", rsvd_pin_o, 2'b00);
  endtask : outs

  task automatic do_rst(input int n);
    repeat (3) @(negedge core_clk);
    rst = 1'b1;
    repeat (n) @(negedge core_clk);
    rst = 1'b0;
    pd = 2'b11;
    pr = 2'b00;
    rsv[0] = 5'h00;
    rsv[1] = 5'h00;
    dn = 1'b1;
    up = 1'b0;
    lp = 1'b1;
    lk = 1'b1;
    act = 2'b00;
    st = 2'b00;
    if (!pme_en) begin
      uw = 2'b00;
      dw = 2'b00;
      pb = 2'b00;
    end
  endtask : do_rst

  // Margins of about ten cycles keep the reads clear of each edge.
  task automatic pwr_seq(input logic f, input logic u, input int dl);
    pwr_up = {u, u};
    pulse(3, f ? 2'b10 : 2'b01);
    st[f] = 1'b1;
    rd(f, `SSC_CFG_OFFSET);
    pwr_up = {!u, !u};
    pulse(3, f ? 2'b10 : 2'b01);
    repeat (`SSC_STREAM_CYC - 14) @(negedge core_clk);
    rd(f, `SSC_CFG_OFFSET);
    repeat (16) @(negedge core_clk);
    uw[f] = u;
    dw[f] = !u;
    rd(f, `SSC_CFG_OFFSET);
    repeat (dl - 25) @(negedge core_clk);
    rd(f, `SSC_CFG_OFFSET);
    repeat (20) @(negedge core_clk);
    st[f] = 1'b0;
    uw[f] = 1'b0;
    dw[f] = 1'b0;
    rd(f, `SSC_CFG_OFFSET);
  endtask : pwr_seq

  // ----------------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------------
  always @(posedge core_clk) begin
    if (cfg_rvalid === 1'b1) begin
      if (exp_q.size() == 0)
        chk("rvalid", 32'h00000001, 32'h00000000);
      else
        chk("rdata", cfg_rdata, exp_q.pop_front());
    end
  end

  initial begin
    #(20000 * 4);
    error_cnt++;
    print_verdict();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    {cfg_rd, cfg_wr, cfg_func, pme_en} = 4'h0;
    cfg_addr = 8'h00;
    cfg_wdata = 32'h00000000;
    cfg_be = 4'hf;
    {card_access, probe_start, probe_done, pwr_req, pwr_up} = 10'h000;
    cb_present_pin = 2'b01;
    seed = 32'h00000002;
    pme_en = 1'b0;
    do_rst(8);
    rd(0, `SSC_CFG_OFFSET);
    rd(1, `SSC_CFG_OFFSET);
    outs();
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      d = seed;
      d[20:16] = rsv[i[0]];
      wr(i[0], `SSC_CFG_OFFSET, d, 4'hf);
      rd(i[0], `SSC_CFG_OFFSET);
      outs();
    end
    wr(0, `SSC_CFG_OFFSET, 32'h00000000, 4'h1);
    wr(1, `SSC_CFG_OFFSET, {9'h000, 2'b11, rsv[1], 16'hc060}, 4'hf);
    wr(0, 8'h84, 32'hffffffff, 4'hf);
    rd(0, 8'h84);
    rd(1, `SSC_CFG_OFFSET);
    cb_present_pin = 2'b10;
    outs();
    wr(1, `SSC_CFG_OFFSET, {9'h000, 2'b00, rsv[1], 16'h0000}, 4'h4);
    outs();
    pulse(0, 2'b10);
    act[1] = 1'b1;
    rd(0, `SSC_CFG_OFFSET);
    rd(1, `SSC_CFG_OFFSET);
    rd(1, `SSC_CFG_OFFSET);
    pulse(1, 2'b10);
    pb[1] = 1'b1;
    rd(1, `SSC_CFG_OFFSET);
    rd(0, `SSC_CFG_OFFSET);
    pulse(2, 2'b10);
    pb[1] = 1'b0;
    rd(1, `SSC_CFG_OFFSET);
    pwr_seq(0, 1'b1, `SSC_UP_DLY_CYC);
    pwr_seq(1, 1'b0, `SSC_DN_DLY_CYC);
    // Context flags survive a reset only while event signalling is on.
    pulse(1, 2'b01);
    pb[0] = 1'b1;
    pwr_up = 2'b11;
    pulse(3, 2'b01);
    repeat (`SSC_STREAM_CYC + 10) @(negedge core_clk);
    uw[0] = 1'b1;
    pme_en = 1'b1;
    do_rst(2);
    rd(0, `SSC_CFG_OFFSET);
    pme_en = 1'b0;
    do_rst(2);
    rd(0, `SSC_CFG_OFFSET);
    outs();
    repeat (4) @(negedge core_clk);
    chk("pending", exp_q.size(), 32'h00000000);
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
